// file: logic/tsc_map.svh
// register offsets, field positions, codes and reset values
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define TSC_OFF_CTRL       32'h0000_0000
`define TSC_OFF_STATUS     32'h0000_0004

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define TSC_CTRL_SOFT_RST  0
`define TSC_CTRL_CUR_LO    1
`define TSC_CTRL_CUR_HI    2
`define TSC_CTRL_CUR_RST   2'h1

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define TSC_ST_ROLE_LO     0
`define TSC_ST_ROLE_HI     2
`define TSC_ST_SER_EN      3
`define TSC_ST_SER_ADR_LO  4
`define TSC_ST_SER_ADR_HI  10
`define TSC_ST_CUR_LO      11
`define TSC_ST_CUR_HI      12
`define TSC_ST_SRC_ATT     13
`define TSC_ST_SNK_ATT     14
`define TSC_ST_FLIPPED     15
`define TSC_ST_SW_ACT      16
`define TSC_ST_CC_RUN      17
`define TSC_ST_DIR_PIN     18
`define TSC_ST_ATT_PIN     19

// ------------------------------------------------------------
// tri-level strap codes
// ------------------------------------------------------------
`define TSC_LVL_LOW        2'h0
`define TSC_LVL_OPEN       2'h1
`define TSC_LVL_HIGH       2'h2

// ------------------------------------------------------------
// advertised current codes
// ------------------------------------------------------------
`define TSC_CUR_NONE       2'h0
`define TSC_CUR_DEF        2'h1
`define TSC_CUR_MID        2'h2
`define TSC_CUR_HIGH       2'h3

// ------------------------------------------------------------
// serial interface addresses and bus responses
// ------------------------------------------------------------
`define TSC_SER_ADR_HIGH   7'h67
`define TSC_SER_ADR_LOW    7'h47
`define TSC_SER_ADR_NONE   7'h00
`define TSC_RESP_OKAY      2'h0
`define TSC_RESP_SLVERR    2'h2
`define TSC_DATA_ZERO      32'h0000_0000

`endif

// file: logic/tsc_pkg.sv
// types shared by the strap configuration block
package tsc_pkg;

	typedef logic [1:0] tsc_level_t;

	typedef enum logic [2:0] {
		TSC_ROLE_DFP = 3'h1,
		TSC_ROLE_DRP = 3'h2,
		TSC_ROLE_UFP = 3'h4
	} tsc_role_e;

	typedef enum logic [2:0] {
		TSC_ST_OFF    = 3'h1,
		TSC_ST_SAMPLE = 3'h2,
		TSC_ST_RUN    = 3'h4
	} tsc_state_e;

endpackage : tsc_pkg

// file: logic/tsc_strap_if.sv
// strap sampling link between top and latch
`timescale 1ns/1ps
interface tsc_strap_if;
	logic               sample;
	tsc_pkg::tsc_level_t level_in;
	tsc_pkg::tsc_level_t held;

	modport owner (output sample, output level_in, input held);
	modport latch (input sample, input level_in, output held);
endinterface : tsc_strap_if

// file: logic/tsc_strap_latch.sv
// holds one strap level between sampling events
`timescale 1ns/1ps
`include "tsc_map.svh"
module tsc_strap_latch (
	input  wire logic aclk,    // system clock
	input  wire logic aresetn, // sync reset, active low
	tsc_strap_if.latch s       // sample strobe and levels
);
	import tsc_pkg::*;

	tsc_level_t held_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			held_q <= `TSC_LVL_OPEN;
		end else if (s.sample) begin
			held_q <= s.level_in;
		end
	end

	assign s.held = held_q;
endmodule : tsc_strap_latch

// file: logic/tsc_top.sv
// strap sampling, role decode and control for the type-c port
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tsc_map.svh"

module tsc_top (
	input  wire logic                aclk,                // clock
	input  wire logic                aresetn,             // sync reset
	input  wire logic [31:0]         s_axi_awaddr,        // write addr
	input  wire logic                s_axi_awvalid,       // write addr valid
	output logic                     s_axi_awready,       // write addr ready
	input  wire logic [31:0]         s_axi_wdata,         // write data
	input  wire logic [3:0]          s_axi_wstrb,         // byte enables
	input  wire logic                s_axi_wvalid,        // write data valid
	output logic                     s_axi_wready,        // write data ready
	output logic [1:0]               s_axi_bresp,         // write response
	output logic                     s_axi_bvalid,        // response valid
	input  wire logic                s_axi_bready,        // response ready
	input  wire logic [31:0]         s_axi_araddr,        // read addr
	input  wire logic                s_axi_arvalid,       // read addr valid
	output logic                     s_axi_arready,       // read addr ready
	output logic [31:0]              s_axi_rdata,         // read data
	output logic [1:0]               s_axi_rresp,         // read response
	output logic                     s_axi_rvalid,        // read valid
	input  wire logic                s_axi_rready,        // read ready
	input  wire tsc_pkg::tsc_level_t port_role_strap,     // role strap
	input  wire tsc_pkg::tsc_level_t current_strap,       // current strap
	input  wire tsc_pkg::tsc_level_t addr_strap,          // address strap
	input  wire logic                config_channel_enable_low, // cc enable
	input  wire logic                main_supply,         // supply present
	input  wire logic                switch_enable_low,   // switch enable
	input  wire logic                bus_power_sense,     // bus power seen
	input  wire logic                cc_attached,         // cc sees partner
	input  wire logic                cc_flipped,          // cc2 orientation
	input  wire logic                cc_drp_as_source,    // dual role as src
	input  wire logic                dir_i,               // orientation pin
	output logic                     dir_o,               // orientation drive
	output logic                     dir_oe,              // orientation oe
	input  wire logic                attach_indicator_in, // attach pin
	output logic                     attach_indicator_out, // attach drive
	output logic                     attach_indicator_oe, // attach oe
	output logic                     switch_active,       // switch running
	output logic                     cc_run,              // cc running
	output tsc_pkg::tsc_role_e       port_role,           // latched role
	output logic [1:0]               adv_current,         // advertised current
	output logic                     sink_attached,       // sink attached
	output logic                     serial_if_enable,    // serial enabled
	output logic [6:0]               serial_if_address    // serial address
);
	import tsc_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic tsc_level_t fix_level(input tsc_level_t lvl);
		fix_level = (lvl == `TSC_LVL_LOW || lvl == `TSC_LVL_HIGH) ?
			lvl : `TSC_LVL_OPEN;
	endfunction : fix_level

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	tsc_state_e  state_q;
	tsc_state_e  state_d;
	logic        cc_on;
	logic        soft_rst_q;
	logic [1:0]  sw_cur_q;
	tsc_role_e   role_d;
	logic        acting_source;
	logic        gpio_mode;
	logic [1:0]  cur_d;
	logic        aw_hold_q;
	logic [31:0] aw_addr_q;
	logic        w_hold_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;
	logic        wr_do;
	logic [31:0] status_w;

	tsc_strap_if role_if ();
	tsc_strap_if addr_if ();

	// ------------------------------------------------------------
	// sampling sequence
	// ------------------------------------------------------------
	// enable active low
	assign cc_on = !config_channel_enable_low && main_supply;

	always_comb begin
		state_d = state_q;
		case (state_q)
			TSC_ST_OFF: begin
				if (cc_on) begin
					state_d = TSC_ST_SAMPLE;
				end
			end
			TSC_ST_SAMPLE: begin
				state_d = cc_on ? TSC_ST_RUN : TSC_ST_OFF;
			end
			TSC_ST_RUN: begin
				if (!cc_on) begin
					state_d = TSC_ST_OFF;
				end else if (soft_rst_q) begin
					state_d = TSC_ST_SAMPLE;
				end
			end
			default: begin
				state_d = TSC_ST_OFF;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= TSC_ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	assign role_if.sample   = (state_q == TSC_ST_SAMPLE);
	assign role_if.level_in = fix_level(port_role_strap);
	assign addr_if.sample   = (state_q == TSC_ST_SAMPLE);
	assign addr_if.level_in = fix_level(addr_strap);

	tsc_strap_latch u_role_latch (
		.aclk    (aclk),
		.aresetn (aresetn),
		.s       (role_if.latch)
	);

	tsc_strap_latch u_addr_latch (
		.aclk    (aclk),
		.aresetn (aresetn),
		.s       (addr_if.latch)
	);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	always_comb begin
		case (role_if.held)
			`TSC_LVL_HIGH: role_d = TSC_ROLE_DFP;
			`TSC_LVL_LOW:  role_d = TSC_ROLE_UFP;
			default:       role_d = TSC_ROLE_DRP;
		endcase
	end

	assign acting_source = (role_d == TSC_ROLE_DFP) ||
		((role_d == TSC_ROLE_DRP) && cc_drp_as_source);
	assign gpio_mode = (addr_if.held == `TSC_LVL_OPEN);

	always_comb begin
		cur_d = `TSC_CUR_NONE;
		if (state_q == TSC_ST_RUN && acting_source) begin
			if (gpio_mode) begin
				case (fix_level(current_strap))
					`TSC_LVL_HIGH: cur_d = `TSC_CUR_HIGH;
					`TSC_LVL_OPEN: cur_d = `TSC_CUR_MID;
					default:       cur_d = `TSC_CUR_DEF;
				endcase
			end else begin
				cur_d = sw_cur_q;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_role            <= TSC_ROLE_DRP;
			adv_current          <= `TSC_CUR_NONE;
			cc_run               <= 1'b0;
			switch_active        <= 1'b0;
			sink_attached        <= 1'b0;
			serial_if_enable     <= 1'b0;
			serial_if_address    <= `TSC_SER_ADR_NONE;
			dir_o                <= 1'b0;
			dir_oe               <= 1'b0;
			attach_indicator_out <= 1'b0;
			attach_indicator_oe  <= 1'b0;
		end else begin
			port_role     <= role_d;
			adv_current   <= cur_d;
			cc_run        <= (state_q == TSC_ST_RUN);
			switch_active <= !switch_enable_low;
			sink_attached <= (state_q == TSC_ST_RUN) && !acting_source &&
				bus_power_sense;
			case (addr_if.held)
				`TSC_LVL_HIGH: begin
					serial_if_enable  <= 1'b1;
					serial_if_address <= `TSC_SER_ADR_HIGH;
				end
				`TSC_LVL_LOW: begin
					serial_if_enable  <= 1'b1;
					serial_if_address <= `TSC_SER_ADR_LOW;
				end
				default: begin
					serial_if_enable  <= 1'b0;
					serial_if_address <= `TSC_SER_ADR_NONE;
				end
			endcase
			dir_o  <= 1'b0;
			dir_oe <= (state_q == TSC_ST_RUN) && cc_attached && cc_flipped;
			attach_indicator_out <= 1'b0;
			attach_indicator_oe  <= (state_q == TSC_ST_RUN) && cc_attached &&
				acting_source;
		end
	end

	// ------------------------------------------------------------
	// register bus, write side
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign wr_do         = aw_hold_q && w_hold_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= `TSC_DATA_ZERO;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_do) begin
			aw_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_q <= 1'b0;
			w_data_q <= `TSC_DATA_ZERO;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_do) begin
			w_hold_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `TSC_RESP_OKAY;
		end else if (wr_do) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (aw_addr_q == `TSC_OFF_CTRL ||
				aw_addr_q == `TSC_OFF_STATUS) ?
				`TSC_RESP_OKAY : `TSC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// control register and soft reset strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_rst_q <= 1'b0;
			sw_cur_q   <= `TSC_CTRL_CUR_RST;
		end else begin
			soft_rst_q <= 1'b0;
			if (wr_do && aw_addr_q == `TSC_OFF_CTRL && w_strb_q[0]) begin
				soft_rst_q <= w_data_q[`TSC_CTRL_SOFT_RST];
				sw_cur_q   <= w_data_q[`TSC_CTRL_CUR_HI:`TSC_CTRL_CUR_LO];
			end
		end
	end

	// ------------------------------------------------------------
	// register bus, read side
	// ------------------------------------------------------------
	always_comb begin
		status_w = `TSC_DATA_ZERO;
		status_w[`TSC_ST_ROLE_HI:`TSC_ST_ROLE_LO]     = port_role;
		status_w[`TSC_ST_SER_EN]                      = serial_if_enable;
		status_w[`TSC_ST_SER_ADR_HI:`TSC_ST_SER_ADR_LO] = serial_if_address;
		status_w[`TSC_ST_CUR_HI:`TSC_ST_CUR_LO]       = adv_current;
		status_w[`TSC_ST_SRC_ATT]                     = attach_indicator_oe;
		status_w[`TSC_ST_SNK_ATT]                     = sink_attached;
		status_w[`TSC_ST_FLIPPED]                     = dir_oe;
		status_w[`TSC_ST_SW_ACT]                      = switch_active;
		status_w[`TSC_ST_CC_RUN]                      = cc_run;
		status_w[`TSC_ST_DIR_PIN]                     = dir_i;
		status_w[`TSC_ST_ATT_PIN]                     = attach_indicator_in;
	end

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= `TSC_RESP_OKAY;
			rdata_q  <= `TSC_DATA_ZERO;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q  <= `TSC_RESP_OKAY;
			rdata_q  <= `TSC_DATA_ZERO;
			if (s_axi_araddr == `TSC_OFF_CTRL) begin
				rdata_q[`TSC_CTRL_CUR_HI:`TSC_CTRL_CUR_LO] <= sw_cur_q;
			end else if (s_axi_araddr == `TSC_OFF_STATUS) begin
				rdata_q <= status_w;
			end else begin
				rresp_q <= `TSC_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
endmodule : tsc_top

// file: verification/tb_top.sv
// self-checking bench for the strap configuration block
`timescale 1ns/1ps
`include "tsc_map.svh"
module tb_top;
	import tsc_pkg::*;
	typedef struct packed {
		tsc_level_t r, a, c;
		logic [2:0] er;
		logic       en;
		logic [6:0] ea;
		logic [1:0] ec;
	} tsc_row_s;
	logic        aclk = 1'b0, aresetn = 1'b0, plug, flip, p_src;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, dir_i, dir_o, dir_oe;
	logic [1:0]  s_axi_bresp, s_axi_rresp, adv_current, r;
	tsc_level_t  port_role_strap, current_strap, addr_strap;
	logic        config_channel_enable_low, main_supply, switch_enable_low;
	logic        bus_power_sense, cc_attached, cc_flipped, cc_drp_as_source;
	logic        attach_indicator_in, attach_indicator_out;
	logic        attach_indicator_oe, switch_active, cc_run, sink_attached;
	logic        serial_if_enable;
	logic [6:0]  serial_if_address;
	tsc_role_e   port_role;
	int          miscompares = 0, comparisons = 0;
	tsc_row_s    rows [6] = '{
		'{`TSC_LVL_HIGH, `TSC_LVL_OPEN, `TSC_LVL_LOW, TSC_ROLE_DFP, 1'b0,
			`TSC_SER_ADR_NONE, `TSC_CUR_DEF},
		'{`TSC_LVL_HIGH, `TSC_LVL_OPEN, `TSC_LVL_OPEN, TSC_ROLE_DFP, 1'b0,
			`TSC_SER_ADR_NONE, `TSC_CUR_MID},
		'{`TSC_LVL_OPEN, `TSC_LVL_OPEN, `TSC_LVL_HIGH, TSC_ROLE_DRP, 1'b0,
			`TSC_SER_ADR_NONE, `TSC_CUR_HIGH},
		'{`TSC_LVL_LOW, `TSC_LVL_OPEN, `TSC_LVL_HIGH, TSC_ROLE_UFP, 1'b0,
			`TSC_SER_ADR_NONE, `TSC_CUR_NONE},
		'{`TSC_LVL_HIGH, `TSC_LVL_HIGH, `TSC_LVL_HIGH, TSC_ROLE_DFP, 1'b1,
			`TSC_SER_ADR_HIGH, `TSC_CUR_DEF},
		'{`TSC_LVL_LOW, `TSC_LVL_LOW, `TSC_LVL_HIGH, TSC_ROLE_UFP, 1'b1,
			`TSC_SER_ADR_LOW, `TSC_CUR_NONE}};

	// open-drain pins with pull-ups
	assign dir_i = dir_oe ? dir_o : 1'b1;
	assign attach_indicator_in = attach_indicator_oe ?
		attach_indicator_out : 1'b1;

	always #5 aclk = ~aclk;

	tsc_top dut_u (.*);
	tsc_partner prt_u (.aclk(aclk), .plug(plug), .flip(flip), .is_src(p_src),
		.cc_attached(cc_attached), .cc_flipped(cc_flipped),
		.cc_drp_as_source(cc_drp_as_source),
		.bus_power_sense(bus_power_sense));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task results;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		chk(nm, {30'h0, e}, {30'h0, g});
	endtask : chk_resp

	task tmo;
		miscompares++;
		$display("[ERR] axi_wait exp done got timeout");
		results();
	endtask : tmo

	task wt(input int n);
		repeat (n) @(posedge aclk);
	endtask : wt

	task axw(input logic [31:0] a, input logic [31:0] v,
		output logic [1:0] rs);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rs = s_axi_bresp;
				break;
			end
		end
		s_axi_bready <= 1'b0;
		if (n == 50)
			tmo();
		@(posedge aclk);
	endtask : axw

	task axr(input logic [31:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				v = s_axi_rdata;
				rs = s_axi_rresp;
				break;
			end
		end
		s_axi_rready <= 1'b0;
		if (n == 50)
			tmo();
		@(posedge aclk);
	endtask : axr

	task relatch;
		axw(`TSC_OFF_CTRL, 32'h0000_0003, r);
		chk_resp("ctrl_wr", `TSC_RESP_OKAY, r);
		wt(8);
	endtask : relatch

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, flip, p_src, switch_enable_low} = '0;
		{config_channel_enable_low, main_supply, plug} = 3'h7;
		s_axi_wstrb = 4'hF;
		{port_role_strap, current_strap, addr_strap} = {3{`TSC_LVL_OPEN}};
		wt(16);
		aresetn <= 1'b1;
		wt(2);
		chk("role", 32'(TSC_ROLE_DRP), 32'(port_role));
		chk("cur", 32'h0, 32'(adv_current));
		chk("awready", 32'h1, 32'(s_axi_awready));
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			config_channel_enable_low <= 1'b1;
			port_role_strap <= rows[i].r;
			addr_strap <= rows[i].a;
			current_strap <= rows[i].c;
			wt(4);
			config_channel_enable_low <= 1'b0;
			wt(8);
			chk("role", 32'(rows[i].er), 32'(port_role));
			chk("ser_en", 32'(rows[i].en), 32'(serial_if_enable));
			chk("ser_adr", 32'(rows[i].ea), 32'(serial_if_address));
			chk("cur", 32'(rows[i].ec), 32'(adv_current));
			chk("att", 32'(rows[i].er != 3'h4), 32'(attach_indicator_oe));
			$display("row %0d done", i);
		end
		port_role_strap <= `TSC_LVL_HIGH;
		wt(6);
		chk("role", 32'(TSC_ROLE_UFP), 32'(port_role));
		relatch();
		chk("role", 32'(TSC_ROLE_DFP), 32'(port_role));
		axr(`TSC_OFF_STATUS, d, r);
		chk("st_role", 32'(TSC_ROLE_DFP), {29'h0, d[2:0]});
		axr(`TSC_OFF_CTRL, d, r);
		chk("ctrl", 32'h0000_0002, d);
		axr(32'h0000_0008, d, r);
		chk_resp("rd_resp", `TSC_RESP_SLVERR, r);
		chk("rd_data", `TSC_DATA_ZERO, d);
		axw(32'h0000_000C, 32'h0000_0001, r);
		chk_resp("wr_resp", `TSC_RESP_SLVERR, r);
		$display("soft reset and bus test done");
		port_role_strap <= `TSC_LVL_LOW;
		relatch();
		p_src <= 1'b1;
		wt(4);
		chk("sink", 32'h1, 32'(sink_attached));
		plug <= 1'b0;
		wt(4);
		chk("sink", 32'h0, 32'(sink_attached));
		plug <= 1'b1;
		flip <= 1'b1;
		wt(4);
		chk("dir_pin", 32'h0, 32'(dir_i));
		flip <= 1'b0;
		wt(4);
		chk("dir_pin", 32'h1, 32'(dir_i));
		$display("sink and orientation test done");
		switch_enable_low <= 1'b1;
		wt(3);
		chk("switch", 32'h0, 32'(switch_active));
		switch_enable_low <= 1'b0;
		wt(3);
		chk("switch", 32'h1, 32'(switch_active));
		main_supply <= 1'b0;
		wt(4);
		chk("cc_run", 32'h0, 32'(cc_run));
		main_supply <= 1'b1;
		wt(8);
		chk("cc_run", 32'h1, 32'(cc_run));
		config_channel_enable_low <= 1'b1;
		wt(4);
		chk("cc_run", 32'h0, 32'(cc_run));
		$display("switch and enable test done");
		results();
	end
endmodule : tb_top

// file: verification/tsc_partner.sv
// type-c port partner seen through the cc logic
`timescale 1ns/1ps
module tsc_partner (
	input wire logic aclk,                    // clock
	input wire logic plug,                    // partner plugged in
	input wire logic flip,                    // plugged on cc2
	input wire logic is_src,                  // partner sources power
	output logic     cc_attached = 1'b0,      // attach seen
	output logic     cc_flipped = 1'b0,       // orientation
	output logic     cc_drp_as_source = 1'b0, // we act as source
	output logic     bus_power_sense = 1'b0   // partner bus power
);
	// only a sourcing partner puts power on the bus
	always @(posedge aclk) begin
		cc_attached <= plug;
		cc_flipped <= plug && flip;
		cc_drp_as_source <= plug && !is_src;
		bus_power_sense <= plug && is_src;
	end
endmodule : tsc_partner

// file: verification/tsc_top_monitor.sv
// concurrent checks on the strap configuration block ports
`timescale 1ns/1ps
module tsc_top_monitor (
	input wire logic               aclk,                      // clock
	input wire logic               aresetn,                   // sync reset
	input wire logic               config_channel_enable_low, // cc enable
	input wire logic               main_supply,               // supply
	input wire logic               switch_enable_low,         // switch en
	input wire logic               bus_power_sense,           // bus power
	input wire logic               cc_attached,               // partner seen
	input wire logic               cc_flipped,                // orientation
	input wire logic               dir_o,                     // dir drive
	input wire logic               dir_oe,                    // dir oe
	input wire logic               attach_indicator_out,      // attach drive
	input wire logic               attach_indicator_oe,       // attach oe
	input wire logic               switch_active,             // switch run
	input wire logic               cc_run,                    // cc running
	input wire tsc_pkg::tsc_role_e port_role,                 // role
	input wire logic [1:0]         adv_current,               // current
	input wire logic               sink_attached,             // sink attach
	input wire logic               serial_if_enable,          // serial en
	input wire logic [6:0]         serial_if_address          // serial addr
);
	import tsc_pkg::*;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ------------------------------------------------------------
	// sequences and properties
	// ------------------------------------------------------------
	sequence s_cc_on;
		$fell(config_channel_enable_low) && main_supply ##1
		(!config_channel_enable_low && main_supply)[*4];
	endsequence
	sequence s_sw_low;
		!switch_enable_low[*2];
	endsequence
	property p_start;
		s_cc_on |-> cc_run;
	endproperty
	property p_cc_off;
		config_channel_enable_low |-> ##2 !cc_run;
	endproperty
	property p_sw;
		s_sw_low |=> switch_active;
	endproperty
	property p_addr;
		(serial_if_enable && (serial_if_address == 7'h67 ||
		serial_if_address == 7'h47)) ||
		(!serial_if_enable && serial_if_address == 7'h00);
	endproperty
	property p_sink;
		sink_attached |-> $past(bus_power_sense);
	endproperty
	property p_dir;
		dir_oe |-> !dir_o && $past(cc_flipped) && $past(cc_attached);
	endproperty
	property p_att;
		attach_indicator_oe |-> !attach_indicator_out && $past(cc_attached);
	endproperty
	property p_cur;
		port_role == TSC_ROLE_UFP && $past(port_role) == TSC_ROLE_UFP
		|-> adv_current == 2'h0;
	endproperty

	a_start: assert property (p_start) else $error("cc not running");
	a_cc_off: assert property (p_cc_off) else $error("cc still runs");
	a_sw: assert property (p_sw) else $error("switch not active");
	a_addr: assert property (p_addr) else $error("bad serial addr");
	a_sink: assert property (p_sink) else $error("sink w/o power");
	a_dir: assert property (p_dir) else $error("bad orientation");
	a_att: assert property (p_att) else $error("bad attach drive");
	a_cur: assert property (p_cur) else $error("sink advertises");
endmodule : tsc_top_monitor

bind tsc_top tsc_top_monitor mon_u (.*);
